/* File: common/pqp_defines.vh */
// Constants for the per-port ingress policing register bank.
// Assumes inclusion by its bare name from the design file.
`ifndef PQP_DEFINES_VH
`define PQP_DEFINES_VH

// Register indices; the byte address is four times the index
`define PQP_IDX_AUTH 12'h803
`define PQP_IDX_POINTER 12'h804
`define PQP_IDX_PRIO_MAP 12'h808
`define PQP_IDX_POLICE 12'h80c
`define PQP_IDX_RATE 12'h820
`define PQP_IDX_BURST 12'h824
`define PQP_IDX_WRED0 12'h830
`define PQP_IDX_WRED1 12'h834
`define PQP_IDX_MONITOR 12'h850

// Authentication mode codes
`define PQP_AUTH_RESERVED 2'b00
`define PQP_AUTH_BLOCK 2'b01
`define PQP_AUTH_PASS 2'b10
`define PQP_AUTH_TRAP 2'b11
`define PQP_AUTH_ACL_BIT 2

// Pointer fields
`define PQP_PORT_IDX_LSB 16
`define PQP_PORT_IDX_MSB 18

// Police control bit positions
`define PQP_POL_DROPPED_COLOR 11
`define PQP_POL_DROP_ALL 10
`define PQP_POL_TYPE_MSB 9
`define PQP_POL_TYPE_LSB 8
`define PQP_POL_PORT_BASED 7
`define PQP_POL_COLOR_MSB 6
`define PQP_POL_COLOR_LSB 5
`define PQP_POL_MARK 4
`define PQP_POL_REMAP 3
`define PQP_POL_DROP_SRP 2
`define PQP_POL_MODE 1
`define PQP_POL_ENABLE 0

// Reset values
`define PQP_RST_PRIO_MAP 16'hfa50
`define PQP_RST_POLICE 12'h020
`define PQP_RST_RATE 32'h10002000
`define PQP_RST_BURST 32'h10003000
`define PQP_RST_WRED_MAX 11'h400
`define PQP_RST_WRED_MIN 11'h080
`define PQP_RST_WRED_MULT 11'h020

// Monitor counter width and probability scaling shift
`define PQP_CNT_W 24
`define PQP_PROB_SHIFT 5

`endif

/* File: hw/pqp_regs.v */
// Per-port ingress policing register bank with Avalon-MM slave access.
// Assumes ref_clk and a synchronous reset from the switch core, and
// datapath strobes on the same clock.
`timescale 1ns/10ps
`include "pqp_defines.vh"

module pqp_regs #(
    parameter NUM_PORTS = 7,
    parameter NUM_QUEUES = 4
) (
    input wire ref_clk,
    input wire reset,
    input wire [13:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire acl_enable,
    output reg auth_enable,
    output reg acl_miss_block,
    output reg acl_miss_forward,
    output reg trap_to_host,
    input wire [2:0] ingress_priority,
    output reg [1:0] regen_queue,
    output reg police_enable,
    output reg color_blind,
    output reg [1:0] non_ip_frame_color,
    output reg color_mark_enable,
    output reg color_remap_enable,
    input wire [2:0] lookup_port,
    input wire [1:0] lookup_queue,
    output reg [15:0] committed_rate,
    output reg [15:0] peak_rate,
    output reg [15:0] committed_burst,
    output reg [15:0] peak_burst,
    input wire [10:0] pm_avg_occupancy,
    input wire [10:0] drop_random,
    input wire drop_check_srp,
    output reg wred_drop,
    input wire pkt_event,
    input wire [2:0] pkt_port,
    input wire [1:0] pkt_queue,
    input wire [1:0] pkt_color,
    input wire pkt_dropped
);

    localparam NUM_ENTRIES = NUM_PORTS * NUM_QUEUES;
    localparam NUM_CNT = NUM_ENTRIES * 4;
    localparam [31:0] LAST_PORT_W = NUM_PORTS - 1;
    localparam [2:0] LAST_PORT = LAST_PORT_W[2:0];

    // Byte-lane merge of a write into a stored word
    function [31:0] pqp_merge;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0] be;
        integer b;
        begin
            pqp_merge = old_val;
            for (b = 0; b < 4; b = b + 1) begin
                if (be[b]) begin
                    pqp_merge[b*8 +: 8] = new_val[b*8 +: 8];
                end
            end
        end
    endfunction

    reg [1:0] auth_mode_ff;
    reg [2:0] port_idx_ff;
    reg [1:0] queue_ptr_ff;
    reg [15:0] prio_map_ff;
    reg [11:0] police_ff;
    reg [31:0] rate_ff [0:NUM_ENTRIES-1];
    reg [31:0] burst_ff [0:NUM_ENTRIES-1];
    reg [10:0] wred_max_ff;
    reg [10:0] wred_min_ff;
    reg [10:0] wred_mult_ff;
    reg [`PQP_CNT_W-1:0] cnt_ff [0:NUM_CNT-1];
    reg ack_ff;
    reg [31:0] nxt_readdata;

    // Bus decode: one wait cycle, then the answer
    wire req = avs_read | avs_write;
    wire wr_go = avs_write & ack_ff & (avs_address[1:0] == 2'b00); // Lands with waitrequest low
    wire [11:0] idx = avs_address[13:2];
    wire sel_port_ok = (port_idx_ff <= LAST_PORT);
    wire [4:0] sel_entry = {port_idx_ff, queue_ptr_ff};
    wire [31:0] pointer_word = {13'h0000, port_idx_ff, 14'h0000, queue_ptr_ff};
    wire [31:0] wred0_word = {5'h00, wred_max_ff, 5'h00, wred_min_ff};
    wire [31:0] wred1_word = {5'h00, wred_mult_ff, 5'h00, pm_avg_occupancy};

    // Write data merged into the current word by byte lane
    wire [31:0] ptr_merged = pqp_merge(pointer_word, avs_writedata, avs_byteenable);
    wire [31:0] pol_merged = pqp_merge({20'h00000, police_ff}, avs_writedata, avs_byteenable);
    wire [31:0] wred0_merged = pqp_merge(wred0_word, avs_writedata, avs_byteenable);
    wire [31:0] wred1_merged = pqp_merge(wred1_word, avs_writedata, avs_byteenable);

    assign avs_waitrequest = req & ~ack_ff;

    // Acknowledge toggles so each request is answered once
    always @(posedge ref_clk) begin
        if (reset) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req & ~ack_ff;
        end
    end

    // Direct control registers
    always @(posedge ref_clk) begin
        if (reset) begin
            auth_mode_ff <= `PQP_AUTH_RESERVED;
            port_idx_ff <= 3'h0;
            queue_ptr_ff <= 2'h0;
            prio_map_ff <= `PQP_RST_PRIO_MAP;
            police_ff <= `PQP_RST_POLICE;
            wred_max_ff <= `PQP_RST_WRED_MAX;
            wred_min_ff <= `PQP_RST_WRED_MIN;
            wred_mult_ff <= `PQP_RST_WRED_MULT;
        end else if (wr_go) begin
            case (idx)
                `PQP_IDX_AUTH: begin
                    if (avs_byteenable[0]) begin
                        auth_mode_ff <= avs_writedata[1:0];
                    end
                end
                `PQP_IDX_POINTER: begin
                    port_idx_ff <= ptr_merged[`PQP_PORT_IDX_MSB:`PQP_PORT_IDX_LSB];
                    queue_ptr_ff <= ptr_merged[1:0];
                end
                `PQP_IDX_PRIO_MAP: begin
                    if (avs_byteenable == 4'hf) begin
                        prio_map_ff <= {avs_writedata[29:28], avs_writedata[25:24],
                                        avs_writedata[21:20], avs_writedata[17:16],
                                        avs_writedata[13:12], avs_writedata[9:8],
                                        avs_writedata[5:4], avs_writedata[1:0]};
                    end
                end
                `PQP_IDX_POLICE: begin
                    police_ff <= pol_merged[11:0];
                end
                `PQP_IDX_WRED0: begin
                    wred_max_ff <= wred0_merged[26:16];
                    wred_min_ff <= wred0_merged[10:0];
                end
                `PQP_IDX_WRED1: begin
                    wred_mult_ff <= wred1_merged[26:16];
                end
                default: begin
                    // Other indices keep every direct register as it is; the rate and burst indices write the indirect storage
                end
            endcase
        end
    end

    // Indirect rate and burst storage, one word per port and queue
    genvar e;
    generate
        for (e = 0; e < NUM_ENTRIES; e = e + 1) begin : g_entry
            always @(posedge ref_clk) begin
                if (reset) begin
                    rate_ff[e] <= `PQP_RST_RATE;
                    burst_ff[e] <= `PQP_RST_BURST;
                end else if (wr_go && sel_port_ok && sel_entry == e) begin
                    if (idx == `PQP_IDX_RATE) begin
                        rate_ff[e] <= pqp_merge(rate_ff[e], avs_writedata, avs_byteenable);
                    end
                    if (idx == `PQP_IDX_BURST) begin
                        burst_ff[e] <= pqp_merge(burst_ff[e], avs_writedata, avs_byteenable);
                    end
                end
            end
        end
    endgenerate

    // Monitor counters: kind 0 dropped, 1 green, 2 yellow, 3 red
    wire dropped_only = police_ff[`PQP_POL_DROPPED_COLOR];
    wire pkt_port_ok = (pkt_port <= LAST_PORT);
    genvar c;
    generate
        for (c = 0; c < NUM_CNT; c = c + 1) begin : g_cnt
            localparam KIND = c % 4;
            wire [1:0] kind = KIND[1:0];
            wire hit_entry = pkt_event && pkt_port_ok && ({pkt_port, pkt_queue} == c / 4);
            wire hit_kind = (kind == 2'b00) ? pkt_dropped :
                            ((pkt_color == kind) && (!dropped_only || pkt_dropped));
            always @(posedge ref_clk) begin
                if (reset) begin
                    cnt_ff[c] <= {`PQP_CNT_W{1'b0}};
                end else if (hit_entry && hit_kind) begin
                    cnt_ff[c] <= cnt_ff[c] + 1'b1;
                end
            end
        end
    endgenerate

    // Read data mux; unmapped addresses read zero
    wire [6:0] cnt_sel = {sel_entry, police_ff[`PQP_POL_TYPE_MSB:`PQP_POL_TYPE_LSB]};
    always @* begin
        nxt_readdata = 32'h00000000;
        case (idx)
            `PQP_IDX_AUTH: begin
                nxt_readdata = {29'h00000000, acl_enable, auth_mode_ff};
            end
            `PQP_IDX_POINTER: begin
                nxt_readdata = pointer_word;
            end
            `PQP_IDX_PRIO_MAP: begin
                nxt_readdata = {2'b00, prio_map_ff[15:14], 2'b00, prio_map_ff[13:12],
                                2'b00, prio_map_ff[11:10], 2'b00, prio_map_ff[9:8],
                                2'b00, prio_map_ff[7:6], 2'b00, prio_map_ff[5:4],
                                2'b00, prio_map_ff[3:2], 2'b00, prio_map_ff[1:0]};
            end
            `PQP_IDX_POLICE: begin
                nxt_readdata = {20'h00000, police_ff};
            end
            `PQP_IDX_RATE: begin
                if (sel_port_ok) begin
                    nxt_readdata = rate_ff[sel_entry];
                end
            end
            `PQP_IDX_BURST: begin
                if (sel_port_ok) begin
                    nxt_readdata = burst_ff[sel_entry];
                end
            end
            `PQP_IDX_WRED0: begin
                nxt_readdata = wred0_word;
            end
            `PQP_IDX_WRED1: begin
                nxt_readdata = wred1_word;
            end
            `PQP_IDX_MONITOR: begin
                if (sel_port_ok) begin
                    nxt_readdata = {8'h00, cnt_ff[cnt_sel]};
                end
            end
            default: begin
                nxt_readdata = 32'h00000000;
            end
        endcase
        if (avs_address[1:0] != 2'b00) begin
            nxt_readdata = 32'h00000000;
        end
    end

    // Read data captured in the wait cycle, stands with waitrequest low
    always @(posedge ref_clk) begin
        if (reset) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && !ack_ff) begin
            avs_readdata <= nxt_readdata;
        end
    end

    // Authentication and access-list steering
    always @(posedge ref_clk) begin
        if (reset) begin
            auth_enable <= 1'b0;
            acl_miss_block <= 1'b0;
            acl_miss_forward <= 1'b0;
            trap_to_host <= 1'b0;
        end else begin
            case (auth_mode_ff)
                `PQP_AUTH_BLOCK: begin
                    auth_enable <= 1'b1;
                    acl_miss_block <= acl_enable;
                    acl_miss_forward <= 1'b0;
                    trap_to_host <= 1'b0;
                end
                `PQP_AUTH_PASS: begin
                    auth_enable <= 1'b0;
                    acl_miss_block <= 1'b0;
                    acl_miss_forward <= acl_enable;
                    trap_to_host <= 1'b0;
                end
                `PQP_AUTH_TRAP: begin
                    auth_enable <= 1'b1;
                    acl_miss_block <= acl_enable;
                    acl_miss_forward <= 1'b0;
                    trap_to_host <= 1'b1;
                end
                default: begin
                    auth_enable <= 1'b0;
                    acl_miss_block <= 1'b0;
                    acl_miss_forward <= 1'b0;
                    trap_to_host <= 1'b0;
                end
            endcase
        end
    end

    // Priority lookup and policing mode outputs
    wire [2:0] rate_port = police_ff[`PQP_POL_PORT_BASED] ? lookup_port : 3'h0;
    wire [4:0] rate_entry = {rate_port, lookup_queue};
    wire rate_ok = (rate_port <= LAST_PORT);
    always @(posedge ref_clk) begin
        if (reset) begin
            regen_queue <= 2'h0;
            police_enable <= 1'b0;
            color_blind <= 1'b0;
            non_ip_frame_color <= 2'h0;
            color_mark_enable <= 1'b0;
            color_remap_enable <= 1'b0;
            committed_rate <= 16'h0000;
            peak_rate <= 16'h0000;
            committed_burst <= 16'h0000;
            peak_burst <= 16'h0000;
        end else begin
            regen_queue <= prio_map_ff[ingress_priority*2 +: 2];
            police_enable <= police_ff[`PQP_POL_ENABLE];
            color_blind <= police_ff[`PQP_POL_ENABLE] & police_ff[`PQP_POL_MODE];
            non_ip_frame_color <= police_ff[`PQP_POL_COLOR_MSB:`PQP_POL_COLOR_LSB];
            color_mark_enable <= police_ff[`PQP_POL_MARK];
            color_remap_enable <= police_ff[`PQP_POL_REMAP] &
                                  ~police_ff[`PQP_POL_MODE];
            if (rate_ok) begin
                committed_rate <= rate_ff[rate_entry][31:16];
                peak_rate <= rate_ff[rate_entry][15:0];
                committed_burst <= burst_ff[rate_entry][31:16];
                peak_burst <= burst_ff[rate_entry][15:0];
            end
        end
    end

    // Packet-memory WRED drop decision
    wire [10:0] over_min = pm_avg_occupancy - wred_min_ff;
    wire [21:0] prob_raw = over_min * wred_mult_ff;
    wire [21:0] prob_shift = prob_raw >> `PQP_PROB_SHIFT;
    wire [10:0] prob = (|prob_shift[21:11]) ? 11'h7ff : prob_shift[10:0];
    wire below_min = (pm_avg_occupancy < wred_min_ff);
    wire above_max = (pm_avg_occupancy > wred_max_ff);
    wire srp_safe = drop_check_srp & ~police_ff[`PQP_POL_DROP_SRP];
    always @(posedge ref_clk) begin
        if (reset) begin
            wred_drop <= 1'b0;
        end else if (!police_ff[`PQP_POL_ENABLE] || srp_safe || below_min) begin
            wred_drop <= 1'b0;
        end else if (above_max && police_ff[`PQP_POL_DROP_ALL]) begin
            wred_drop <= 1'b1;
        end else begin
            wred_drop <= (drop_random < prob);
        end
    end

endmodule // pqp_regs

/* File: test/pqp_regs_properties.sv */
// Concurrent checks on the ports of the ingress policing register bank.
// Assumes it is bound into pqp_regs; one clock, synchronous reset.
`timescale 1ns/10ps
module pqp_regs_properties (
    input wire ref_clk,
    input wire reset,
    input wire [13:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire acl_enable,
    input wire auth_enable,
    input wire acl_miss_block,
    input wire acl_miss_forward,
    input wire trap_to_host,
    input wire police_enable,
    input wire color_blind,
    input wire wred_drop,
    input wire [10:0] pm_avg_occupancy
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    // Request in its wait cycle, and a read finishing at one address
    sequence req_wait;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence rd_done(a);
        avs_read && !avs_waitrequest && avs_address == a;
    endsequence

    chk_one_wait: assert property (req_wait |=> !avs_waitrequest)
        else $error("waitrequest held longer than one cycle");
    chk_auth_readback: assert property (
        rd_done(14'h200c) |-> avs_readdata[7:2] == {5'h00, $past(acl_enable)})
        else $error("auth readback wrong");
    chk_mode_block: assert property (
        auth_enable && !trap_to_host |-> acl_miss_block == $past(acl_enable) && !acl_miss_forward)
        else $error("block mode outputs wrong");
    chk_mode_pass: assert property (
        acl_miss_forward |-> !auth_enable && !acl_miss_block && !trap_to_host)
        else $error("pass mode outputs wrong");
    chk_mode_trap: assert property (
        trap_to_host |-> auth_enable && acl_miss_block == $past(acl_enable))
        else $error("trap mode outputs wrong");
    chk_blind_gate: assert property (color_blind |-> police_enable)
        else $error("color blind without policing");
    chk_police_off: assert property (
        !police_enable [*2] |-> !wred_drop)
        else $error("drop while policing disabled");
    chk_pointer_fields: assert property (
        rd_done(14'h2010) |-> (avs_readdata & 32'hfff8fffc) == 32'h0)
        else $error("pointer reserved bits set");
    chk_map_nibbles: assert property (
        rd_done(14'h2020) |-> (avs_readdata & 32'hcccccccc) == 32'h0)
        else $error("map reserved bits set");
    chk_occupancy_view: assert property (
        rd_done(14'h20d0) |-> avs_readdata[10:0] == $past(pm_avg_occupancy)
            && (avs_readdata & 32'hf800f800) == 32'h0)
        else $error("second memory word wrong");
endmodule // pqp_regs_properties

bind pqp_regs pqp_regs_properties u_props (.ref_clk, .reset, .avs_address, .avs_read,
    .avs_write, .avs_readdata, .avs_waitrequest, .acl_enable, .auth_enable, .acl_miss_block,
    .acl_miss_forward, .trap_to_host, .police_enable, .color_blind, .wred_drop,
    .pm_avg_occupancy);

/* File: test/tb_top.sv */
// Self-checking bench for the ingress policing register bank.
// Assumes pqp_regs and its defines header are on the include path.
`timescale 1ns/10ps
`include "pqp_defines.vh"
module tb_top;
    localparam logic [13:0] A_AUTH = {`PQP_IDX_AUTH, 2'b00};
    localparam logic [13:0] A_PTR = {`PQP_IDX_POINTER, 2'b00};
    localparam logic [13:0] A_MAP = {`PQP_IDX_PRIO_MAP, 2'b00};
    localparam logic [13:0] A_POL = {`PQP_IDX_POLICE, 2'b00};
    localparam logic [13:0] A_RATE = {`PQP_IDX_RATE, 2'b00};
    localparam logic [13:0] A_BURST = {`PQP_IDX_BURST, 2'b00};
    localparam logic [13:0] A_WR0 = {`PQP_IDX_WRED0, 2'b00};
    localparam logic [13:0] A_WR1 = {`PQP_IDX_WRED1, 2'b00};
    localparam logic [13:0] A_MON = {`PQP_IDX_MONITOR, 2'b00};
    logic ref_clk, reset, avs_read, avs_write, avs_waitrequest, acl_enable, auth_enable;
    logic acl_miss_block, acl_miss_forward, trap_to_host, police_enable, color_blind;
    logic color_mark_enable, color_remap_enable, drop_check_srp, wred_drop, pkt_event;
    logic pkt_dropped;
    logic [13:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable;
    logic [2:0] ingress_priority, lookup_port, pkt_port;
    logic [1:0] regen_queue, non_ip_frame_color, lookup_queue, pkt_queue, pkt_color;
    logic [15:0] committed_rate, peak_rate, committed_burst, peak_burst;
    logic [10:0] pm_avg_occupancy, drop_random;
    logic [3:0] auth_tab [4] = '{4'h0, 4'hc, 4'h2, 4'hd};
    logic [31:0] cnt_tab [8] = '{32'h2, 32'h1, 32'h1, 32'h2, 32'h4, 32'h1, 32'h2, 32'h3};
    int err_count, comparisons, i;

    pqp_regs dut (.ref_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .acl_enable, .auth_enable,
        .acl_miss_block, .acl_miss_forward, .trap_to_host, .ingress_priority, .regen_queue,
        .police_enable, .color_blind, .non_ip_frame_color, .color_mark_enable,
        .color_remap_enable, .lookup_port, .lookup_queue, .committed_rate, .peak_rate,
        .committed_burst, .peak_burst, .pm_avg_occupancy, .drop_random, .drop_check_srp,
        .wred_drop, .pkt_event, .pkt_port, .pkt_queue, .pkt_color, .pkt_dropped);

    // Counts, verdict and end of run
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask

    // One Avalon transfer, held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [13:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int n;
        logic w;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        w = 1'b1;
        for (n = 0; n < 16 && w; n++) begin
            @(posedge ref_clk);
            w = avs_waitrequest;
            rd = avs_readdata;
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (w) begin
            err_count++;
            close_out();
        end
    endtask

    task automatic rd_chk(input string what, input logic [13:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'h0);
        chk(what, exp, rd);
    endtask

    // Lets registered outputs follow inputs set at the last edge
    task automatic settle();
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic qmap(input logic alt);
        for (int p = 0; p < 8; p++) begin
            @(posedge ref_clk);
            ingress_priority <= p[2:0];
            settle();
            chk("queue", alt ? {30'h0, p[1:0]} : {30'h0, p[2:1]}, {30'h0, regen_queue});
        end
    endtask

    task automatic look(input logic [2:0] p, input logic [1:0] q);
        @(posedge ref_clk);
        lookup_port <= p;
        lookup_queue <= q;
        settle();
    endtask

    task automatic drop_case(input logic [31:0] pol, input logic [10:0] occ,
                             input logic [10:0] rnd, input logic srp, input logic exp);
        bus(1'b1, A_POL, pol, 4'hf);
        @(posedge ref_clk);
        pm_avg_occupancy <= occ;
        drop_random <= rnd;
        drop_check_srp <= srp;
        settle();
        chk("drop", {31'h0, exp}, {31'h0, wred_drop});
    endtask

    task automatic ev(input logic [1:0] c, input logic dr);
        @(posedge ref_clk);
        pkt_event <= 1'b1;
        pkt_port <= 3'd1;
        pkt_queue <= 2'd2;
        pkt_color <= c;
        pkt_dropped <= dr;
        @(posedge ref_clk);
        pkt_event <= 1'b0;
    endtask

    // Free-running 50 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Main sequence
    initial begin
        {reset, avs_read, avs_write, acl_enable, drop_check_srp, pkt_event} = 6'h20;
        {avs_address, avs_writedata, avs_byteenable, ingress_priority} = '0;
        {lookup_port, lookup_queue, drop_random, pkt_port, pkt_queue, pkt_color} = '0;
        pkt_dropped = 1'b0;
        pm_avg_occupancy = 11'h155;
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        rd_chk("auth", A_AUTH, 32'h0);
        rd_chk("pointer", A_PTR, 32'h0);
        rd_chk("map", A_MAP, 32'h33221100);
        rd_chk("police", A_POL, 32'h20);
        rd_chk("rate", A_RATE, 32'h10002000);
        rd_chk("burst", A_BURST, 32'h10003000);
        rd_chk("wred0", A_WR0, 32'h04000080);
        rd_chk("wred1", A_WR1, 32'h00200155);
        qmap(1'b0);
        $display("test reset values done");
        @(posedge ref_clk);
        acl_enable <= 1'b1;
        for (i = 0; i < 4; i++) begin
            bus(1'b1, A_AUTH, {24'h0, 6'h3f, i[1:0]}, 4'hf);
            rd_chk("auth mode", A_AUTH, {29'h1, i[1:0]});
            chk("auth outs", {28'h0, auth_tab[i]},
                {28'h0, auth_enable, acl_miss_block, acl_miss_forward, trap_to_host});
        end
        $display("test auth modes done");
        bus(1'b1, A_MAP, 32'hfedcba98, 4'h3);
        rd_chk("map partial", A_MAP, 32'h33221100);
        bus(1'b1, A_MAP, 32'hfedcba98, 4'hf);
        rd_chk("map", A_MAP, 32'h32103210);
        qmap(1'b1);
        $display("test queue map done");
        bus(1'b1, A_POL, 32'hffffffff, 4'hf);
        rd_chk("police", A_POL, 32'h00000fff);
        chk("pol outs", 32'h3e, {26'h0, police_enable, color_blind, non_ip_frame_color,
            color_mark_enable, color_remap_enable});
        bus(1'b1, A_POL, 32'h0000000d, 4'hf);
        settle();
        chk("pol outs", 32'h21, {26'h0, police_enable, color_blind, non_ip_frame_color,
            color_mark_enable, color_remap_enable});
        bus(1'b1, A_POL, 32'h000000fe, 4'hf);
        settle();
        chk("pol outs", 32'h0e, {26'h0, police_enable, color_blind, non_ip_frame_color,
            color_mark_enable, color_remap_enable});
        $display("test police control done");
        bus(1'b1, A_POL, 32'h00000081, 4'hf);
        bus(1'b1, A_PTR, 32'hffffffff, 4'hf);
        rd_chk("pointer", A_PTR, 32'h00070003);
        rd_chk("rate port 7", A_RATE, 32'h0);
        rd_chk("unmapped", 14'h2004, 32'h0);
        bus(1'b1, A_PTR, 32'h00020003, 4'hf);
        bus(1'b1, A_RATE, 32'haaaa5555, 4'hf);
        bus(1'b1, A_BURST, 32'h12343456, 4'hf);
        rd_chk("rate", A_RATE, 32'haaaa5555);
        rd_chk("burst", A_BURST, 32'h12343456);
        bus(1'b1, A_PTR, 32'h00020002, 4'hf);
        rd_chk("rate other queue", A_RATE, 32'h10002000);
        look(3'd2, 2'd3);
        chk("rate out", 32'haaaa5555, {committed_rate, peak_rate});
        chk("burst out", 32'h12343456, {committed_burst, peak_burst});
        bus(1'b1, A_POL, 32'h00000001, 4'hf);
        look(3'd2, 2'd3);
        chk("aggregate rate", 32'h10002000, {committed_rate, peak_rate});
        $display("test indirect limits done");
        bus(1'b1, A_WR0, 32'hffffffff, 4'hf);
        rd_chk("wred0 mask", A_WR0, 32'h07ff07ff);
        bus(1'b1, A_WR0, 32'h01000040, 4'hf);
        bus(1'b1, A_WR1, 32'hffffffff, 4'hf);
        rd_chk("wred1", A_WR1, 32'h07ff0155);
        bus(1'b1, A_WR1, 32'h00200000, 4'hf);
        drop_case(32'h401, 11'h030, 11'h000, 1'b0, 1'b0);
        drop_case(32'h001, 11'h080, 11'h000, 1'b0, 1'b1);
        drop_case(32'h001, 11'h080, 11'h7ff, 1'b0, 1'b0);
        drop_case(32'h401, 11'h200, 11'h7ff, 1'b0, 1'b1);
        drop_case(32'h001, 11'h200, 11'h7ff, 1'b0, 1'b0);
        drop_case(32'h401, 11'h200, 11'h7ff, 1'b1, 1'b0);
        drop_case(32'h405, 11'h200, 11'h7ff, 1'b1, 1'b1);
        drop_case(32'h400, 11'h200, 11'h7ff, 1'b0, 1'b0);
        $display("test drop decisions done");
        bus(1'b1, A_PTR, 32'h00010002, 4'hf);
        for (i = 0; i < 8; i++) begin
            if (i[1:0] == 2'b00) begin
                bus(1'b1, A_POL, {20'h0, i[2], 11'h000}, 4'hf);
                ev(2'b01, 1'b0);
                ev(2'b10, 1'b1);
                ev(2'b11, 1'b0);
                ev(2'b11, 1'b1);
            end
            bus(1'b1, A_POL, {20'h0, i[2], 1'b0, i[1:0], 8'h00}, 4'hf);
            rd_chk("monitor", A_MON, cnt_tab[i]);
        end
        $display("test monitor counts done");
        close_out();
    end
endmodule // tb_top
